// ==== rtl/link_irq_pkg.sv ====
/*
 * Constants shared by the link interrupt enable block: register offsets,
 * field positions and reset values.
 * Assumes the serial control bus slave decodes an 8-bit register address.
 */
package link_irq_pkg;

    // Register offsets on the serial control bus
    localparam logic [7:0] INTERRUPT_CONTROL_ADDR = 8'hC6;
    localparam logic [7:0] INTERRUPT_STATUS_ADDR = 8'hC7;

    // Field positions, shared by control and status; global enable is in control only
    localparam int INDIRECT_DONE_BIT = 7;
    localparam int RECEIVER_FOUND_BIT = 6;
    localparam int DOWNSTREAM_IRQ_BIT = 5;
    localparam int GLOBAL_ENABLE_BIT = 0;

    // Reset values
    localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h00;
    localparam logic [7:0] INTERRUPT_STATUS_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // Writable bits of the control register; reserved bits read as zero
    localparam logic [7:0] INTERRUPT_CONTROL_MASK = 8'hE1;

endpackage

// ==== rtl/sticky_flag.sv ====
/*
 * One sticky event flag: set by a hardware event, cleared by software.
 * Assumes set and clear are single-cycle pulses synchronous to i_clk.
 */
`timescale 1ns/10ps
`default_nettype none

module sticky_flag
(
    input wire logic i_clk, // System clock
    input wire logic i_rst_n, // Asynchronous reset, active low
    input wire logic i_set, // Event pulse
    input wire logic i_clr, // Software clear pulse
    output logic o_flag // Registered flag
);

    // Whole state of the flag
    typedef struct packed {
        logic flag;
    } flag_state_s;

    flag_state_s state_q; // Registered state
    flag_state_s state_d; // Next state

    // Set beats clear so an event landing on the clear cycle survives
    always_comb
    begin
        state_d = state_q;
        if (i_set)
        begin
            state_d.flag = 1'b1;
        end
        else if (i_clr)
        begin
            state_d.flag = 1'b0;
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign o_flag = state_q.flag;

endmodule

`default_nettype wire

// ==== rtl/link_interrupt_enable.sv ====
/*
 * Interrupt enable control for a video link serializer: the
 * interrupt_control register, the read-only interrupt_status flags and
 * the gated interrupt output to the host controller.
 * Assumes a serial control bus slave outside this block turns bus
 * transactions into single-cycle read and write strobes with an 8-bit
 * address, all synchronous to i_clk, and takes read data one cycle later.
 * Assumes the receiver-detect qualify bit and the lock level come from
 * registers and status logic outside this block, already in this clock.
 */
// Contract
// - Interrupt output only while global enable set
// - Bit 7 enables indirect access done interrupt
// - Bit 6 enables receiver detected interrupt
// - Bit 5 forwards downstream receiver interrupt requests
// - Each cause has its own read-only status bit
// - Qualify bit adds receive lock to detection
`timescale 1ns/10ps
`default_nettype none

module link_interrupt_enable
(
    input wire logic i_clk, // System clock, 25 MHz
    input wire logic i_rst_n, // Asynchronous reset, active low
    input wire logic [7:0] i_reg_addr, // Register address
    input wire logic i_reg_wr, // Write strobe, one cycle
    input wire logic [7:0] i_reg_wdata, // Write data
    input wire logic i_reg_rd, // Read strobe, one cycle
    input wire logic i_indirect_done, // Indirect access completed, pulse
    input wire logic i_receiver_found, // Downstream receiver detected, pulse
    input wire logic i_rx_lock, // Receive lock from the receiver, level
    input wire logic i_receiver_found_qualify, // Require lock for detect
    input wire logic i_downstream_irq, // Downstream interrupt request, pulse
    output logic [7:0] o_reg_rdata, // Read data, valid with o_reg_rvalid
    output logic o_reg_rvalid, // Read data valid, one cycle
    output logic o_irq // Interrupt to host controller, active high
);

    // Whole registered state of the block; reserved control bits 4..1
    // are not stored at all, which saves flops and makes them read as
    // zero without any masking on the write path
    typedef struct packed {
        logic indirect_done_irq_enable; // Control bit 7
        logic receiver_found_irq_enable; // Control bit 6
        logic downstream_irq_enable; // Control bit 5
        logic global_irq_enable; // Control bit 0
        logic [7:0] rdata; // Read data holding register
        logic rvalid; // Read answer strobe
        logic irq; // Interrupt output register
    } ctrl_state_s;

    ctrl_state_s state_q; // Registered state
    ctrl_state_s state_d; // Next state

    // Address decode
    logic ctrl_sel; // Control register addressed
    logic status_sel; // Status register addressed
    logic status_rd; // Status read, clears the flags

    // Status flags from the sticky flag cells
    logic indirect_done_flag;
    logic receiver_found_flag;
    logic downstream_irq_flag;

    // Qualified detection event
    logic receiver_found_event;

    // Register images as a read would see them
    logic [7:0] status_image; // Status, reserved bits zero
    logic [7:0] control_image; // Control, reserved bits zero

    // Full 8-bit compare; loose decoding would alias other registers
    // of the shared bus onto these two
    assign ctrl_sel = (i_reg_addr == link_irq_pkg::INTERRUPT_CONTROL_ADDR);
    assign status_sel = (i_reg_addr == link_irq_pkg::INTERRUPT_STATUS_ADDR);

    // Reading the status clears it; the read returns the pre-clear value
    assign status_rd = i_reg_rd && status_sel;

    // With qualify set, detection alone is not enough: lock must be present
    // Limitation: lock is looked at on the detect cycle only; a lock that
    // comes later does not revive a dropped detection
    assign receiver_found_event = i_receiver_found &&
                                  (!i_receiver_found_qualify || i_rx_lock);

    // All three flags clear together on one status read; a cause firing
    // on the clearing edge itself is kept, since the flag cell lets the
    // set win, so no event slips between read and service routine
    // Indirect access done flag, set regardless of enable so it can be polled
    sticky_flag u_indirect_done_flag
    (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_set(i_indirect_done),
        .i_clr(status_rd),
        .o_flag(indirect_done_flag)
    );

    // Receiver detected flag
    sticky_flag u_receiver_found_flag
    (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_set(receiver_found_event),
        .i_clr(status_rd),
        .o_flag(receiver_found_flag)
    );

    // Downstream interrupt request flag
    sticky_flag u_downstream_irq_flag
    (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_set(i_downstream_irq),
        .i_clr(status_rd),
        .o_flag(downstream_irq_flag)
    );

    // Status image, one bit per cause
    always_comb
    begin
        // Start from the reset image so spare bits stay zero
        status_image = link_irq_pkg::INTERRUPT_STATUS_RESET;
        status_image[link_irq_pkg::INDIRECT_DONE_BIT] = indirect_done_flag;
        status_image[link_irq_pkg::RECEIVER_FOUND_BIT] = receiver_found_flag;
        status_image[link_irq_pkg::DOWNSTREAM_IRQ_BIT] = downstream_irq_flag;
    end

    // Control image as read back
    always_comb
    begin
        // Unstored bits come from the zero base
        control_image = 8'h00;
        control_image[link_irq_pkg::INDIRECT_DONE_BIT] = state_q.indirect_done_irq_enable;
        control_image[link_irq_pkg::RECEIVER_FOUND_BIT] = state_q.receiver_found_irq_enable;
        control_image[link_irq_pkg::DOWNSTREAM_IRQ_BIT] = state_q.downstream_irq_enable;
        control_image[link_irq_pkg::GLOBAL_ENABLE_BIT] = state_q.global_irq_enable;
    end

    // Next state: register writes, read answer and interrupt output
    always_comb
    begin
        // Hold everything by default; the read answer is a one-cycle pulse
        state_d = state_q;
        state_d.rvalid = 1'b0;

        // Control writes; status writes are ignored since it is read-only
        if (i_reg_wr && ctrl_sel)
        begin
            // Only the four stored bits land; the rest of the byte is dropped
            state_d.indirect_done_irq_enable =
                i_reg_wdata[link_irq_pkg::INDIRECT_DONE_BIT];
            state_d.receiver_found_irq_enable =
                i_reg_wdata[link_irq_pkg::RECEIVER_FOUND_BIT];
            state_d.downstream_irq_enable =
                i_reg_wdata[link_irq_pkg::DOWNSTREAM_IRQ_BIT];
            state_d.global_irq_enable =
                i_reg_wdata[link_irq_pkg::GLOBAL_ENABLE_BIT];
        end

        // Reads answer one cycle later; unmapped offsets read as zero
        if (i_reg_rd)
        begin
            state_d.rvalid = 1'b1;
            if (ctrl_sel)
            begin
                // Mask keeps reserved bits zero even if the image grows
                state_d.rdata = control_image & link_irq_pkg::INTERRUPT_CONTROL_MASK;
            end
            else if (status_sel)
            begin
                // Pre-clear value; the flag cells clear on this same edge
                state_d.rdata = status_image;
            end
            else
            begin
                // Unmapped offsets still answer so the bus slave never stalls
                state_d.rdata = link_irq_pkg::UNMAPPED_READ_VALUE;
            end
        end

        // Output follows the flags one cycle late so it comes from a flop;
        // the enables are the live ones, so disabling drops it next cycle;
        // one cycle of latency is traded for a glitch-free pin
        state_d.irq = state_q.global_irq_enable &&
            ((indirect_done_flag && state_q.indirect_done_irq_enable) ||
             (receiver_found_flag && state_q.receiver_found_irq_enable) ||
             (downstream_irq_flag && state_q.downstream_irq_enable));
    end

    // State register; reset loads the defaults field by field, constants only
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_q.indirect_done_irq_enable <=
                link_irq_pkg::INTERRUPT_CONTROL_RESET[link_irq_pkg::INDIRECT_DONE_BIT];
            state_q.receiver_found_irq_enable <=
                link_irq_pkg::INTERRUPT_CONTROL_RESET[link_irq_pkg::RECEIVER_FOUND_BIT];
            state_q.downstream_irq_enable <=
                link_irq_pkg::INTERRUPT_CONTROL_RESET[link_irq_pkg::DOWNSTREAM_IRQ_BIT];
            state_q.global_irq_enable <=
                link_irq_pkg::INTERRUPT_CONTROL_RESET[link_irq_pkg::GLOBAL_ENABLE_BIT];
            state_q.rdata <= link_irq_pkg::UNMAPPED_READ_VALUE;
            state_q.rvalid <= 1'b0;
            state_q.irq <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Outputs straight from flops
    // No logic after these flops, so the host sees clean edges
    assign o_reg_rdata = state_q.rdata;
    assign o_reg_rvalid = state_q.rvalid;
    assign o_irq = state_q.irq;

endmodule

`default_nettype wire

// ==== dv/link_interrupt_enable_chk.sv ====
/* Port checker for link_interrupt_enable.
   Assumes it is bound to the design top, one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module link_interrupt_enable_chk
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    input wire logic i_indirect_done,
    input wire logic i_receiver_found,
    input wire logic i_rx_lock,
    input wire logic i_receiver_found_qualify,
    input wire logic i_downstream_irq,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic o_irq
);
    logic [7:0] ctl_q; // Shadow of the control register
    logic st_rd; // Status read strobe
    assign st_rd = i_reg_rd && (i_reg_addr == link_irq_pkg::INTERRUPT_STATUS_ADDR);
    // Shadow tracks taken writes, reserved bits masked as the design does
    always_ff @(posedge i_clk or negedge i_rst_n)
        if (!i_rst_n)
            ctl_q <= 8'h00;
        else if (i_reg_wr && i_reg_addr == link_irq_pkg::INTERRUPT_CONTROL_ADDR)
            ctl_q <= i_reg_wdata & link_irq_pkg::INTERRUPT_CONTROL_MASK;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    property p_gated; o_irq |-> $past(ctl_q[0]); endproperty
    a_gated: assert property (p_gated) else $error("irq without global enable");
    property p_done; i_indirect_done && ctl_q[7] && ctl_q[0] && !i_reg_wr |=> ##1 o_irq; endproperty
    a_done: assert property (p_done) else $error("no irq on indirect done");
    property p_found;
        i_receiver_found && (!i_receiver_found_qualify || i_rx_lock) && ctl_q[6] && ctl_q[0]
        && !i_reg_wr |=> ##1 o_irq;
    endproperty
    a_found: assert property (p_found) else $error("no irq on receiver found");
    property p_down; i_downstream_irq && ctl_q[5] && ctl_q[0] && !i_reg_wr |=> ##1 o_irq; endproperty
    a_down: assert property (p_down) else $error("no irq on downstream request");
    property p_rvalid; o_reg_rvalid == $past(i_reg_rd); endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer timing");
    property p_st_rsv; st_rd |=> o_reg_rdata[4:0] == 5'h00; endproperty
    a_st_rsv: assert property (p_st_rsv) else $error("status spare bits set");
    property p_clear;
        st_rd && !i_indirect_done && !i_receiver_found && !i_downstream_irq |=> ##1 !o_irq;
    endproperty
    a_clear: assert property (p_clear) else $error("irq stays after status read");
    property p_hold; !i_reg_rd && !i_reg_wr ##1 o_irq |=> o_irq; endproperty
    a_hold: assert property (p_hold) else $error("irq dropped without cause");
endmodule
bind link_interrupt_enable link_interrupt_enable_chk link_interrupt_enable_chk_inst
(
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata),
    .i_reg_rd(i_reg_rd),
    .i_indirect_done(i_indirect_done),
    .i_receiver_found(i_receiver_found),
    .i_rx_lock(i_rx_lock),
    .i_receiver_found_qualify(i_receiver_found_qualify),
    .i_downstream_irq(i_downstream_irq),
    .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid),
    .o_irq(o_irq)
);
`default_nettype wire

// ==== dv/host_model.sv ====
/* Host controller model: one-cycle register strobes.
   Assumes read data answers one cycle after the strobe edge. */
`timescale 1ns/10ps
`default_nettype none
module host_model
(
    input wire logic i_clk,
    output logic [7:0] o_addr,
    output logic o_wr,
    output logic [7:0] o_wdata,
    output logic o_rd
);
    // Idle bus at time zero
    initial
    begin
        o_addr = 8'h00;
        o_wr = 1'b0;
        o_wdata = 8'h00;
        o_rd = 1'b0;
    end
    // One strobe; strobes drop to zero, address and data are inverted so stale values never look valid
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr <= w;
        o_rd <= !w;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
        #1;
    endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
/* Self-checking bench for link_interrupt_enable.
   Assumes host_model and the bound checker are compiled before it. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk, rst_n, wr, rd, rvalid, irq, lock, qual;
    logic [7:0] addr, wdata, rdata;
    logic [2:0] ev; // Events: done, found, downstream
    int bad_count = 0;
    int checked = 0;
    host_model host_model_inst (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_wdata(wdata), .o_rd(rd));
    link_interrupt_enable link_interrupt_enable_inst (.i_clk(clk), .i_rst_n(rst_n),
        .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
        .i_indirect_done(ev[2]), .i_receiver_found(ev[1]), .i_rx_lock(lock),
        .i_receiver_found_qualify(qual), .i_downstream_irq(ev[0]),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_irq(irq));
    // 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp)
            bad_count++;
    endtask
    // Read must answer in the very next cycle
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host_model_inst.xfer(1'b0, a, 8'h00);
        chk({7'h00, rvalid}, 8'h01);
        chk(rdata, exp);
    endtask
    task automatic irq_is(input logic exp);
        @(posedge clk);
        #1;
        chk({7'h00, irq}, {7'h00, exp});
    endtask
    task automatic pulse(input logic [2:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 3'h0;
    endtask
    task automatic t_regs;
        rd_chk(8'hC6, 8'h00);
        rd_chk(8'hC7, 8'h00);
        host_model_inst.xfer(1'b1, 8'hC6, 8'hFF);
        rd_chk(8'hC6, 8'hE1);
        host_model_inst.xfer(1'b1, 8'hC7, 8'hFF);
        chk(rdata, 8'hE1);
        rd_chk(8'hC7, 8'h00);
        rd_chk(8'h55, 8'h00);
        $display("test regs done");
    endtask
    // Each source alone: other enables on first, then its own
    task automatic t_sources;
        logic [7:0] b;
        for (int i = 0; i < 3; i++)
        begin
            b = 8'h80 >> i;
            host_model_inst.xfer(1'b1, 8'hC6, (8'hE0 & ~b) | 8'h01);
            pulse(3'b100 >> i);
            irq_is(1'b0);
            rd_chk(8'hC7, b);
            host_model_inst.xfer(1'b1, 8'hC6, b | 8'h01);
            pulse(3'b100 >> i);
            irq_is(1'b1);
            rd_chk(8'hC7, b);
            irq_is(1'b0);
        end
        $display("test sources done");
    endtask
    task automatic t_global;
        host_model_inst.xfer(1'b1, 8'hC6, 8'hE0);
        pulse(3'h7);
        irq_is(1'b0);
        host_model_inst.xfer(1'b1, 8'hC6, 8'hE1);
        irq_is(1'b1);
        host_model_inst.xfer(1'b1, 8'hC6, 8'hE0);
        irq_is(1'b0);
        host_model_inst.xfer(1'b1, 8'hC6, 8'hE1);
        irq_is(1'b1);
        rd_chk(8'hC7, 8'hE0);
        irq_is(1'b0);
        $display("test global done");
    endtask
    // Detect without lock is dropped when qualified
    task automatic t_qualify;
        host_model_inst.xfer(1'b1, 8'hC6, 8'h41);
        @(posedge clk);
        qual <= 1'b1;
        pulse(3'b010);
        irq_is(1'b0);
        rd_chk(8'hC7, 8'h00);
        @(posedge clk);
        lock <= 1'b1;
        pulse(3'b010);
        irq_is(1'b1);
        rd_chk(8'hC7, 8'h40);
        $display("test qualify done");
    endtask
    // Event on the clearing read's own edge must survive the clear
    task automatic t_set_wins;
        pulse(3'b001);
        fork
            host_model_inst.xfer(1'b0, 8'hC7, 8'h00);
            pulse(3'b001);
        join
        chk({7'h00, rvalid}, 8'h01);
        chk(rdata, 8'h20);
        rd_chk(8'hC7, 8'h20);
        rd_chk(8'hC7, 8'h00);
        $display("test set wins done");
    endtask
    // Reset in mid-run drops the output and clears enables and flags
    task automatic t_reset;
        host_model_inst.xfer(1'b1, 8'hC6, 8'hE1);
        pulse(3'h7);
        irq_is(1'b1);
        @(posedge clk);
        rst_n <= 1'b0;
        irq_is(1'b0);
        @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(8'hC6, 8'h00);
        rd_chk(8'hC7, 8'h00);
        $display("test reset done");
    endtask
    task automatic end_sim;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        rst_n = 1'b0;
        ev = 3'h0;
        lock = 1'b0;
        qual = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_sources();
        t_global();
        t_qualify();
        t_set_wins();
        t_reset();
        end_sim();
    end
    // Hang guard
    initial
    begin
        #100000;
        bad_count++;
        end_sim();
    end
endmodule
`default_nettype wire
